// ---- logic/bwc_pkg.sv ----
// package: register map, resets and carriers of the bridge window and control registers
package bwc_pkg;

  // config dword byte offsets
  localparam logic [7:0] OFS_PREF_LIMIT_HI = 8'h2C;
  localparam logic [7:0] OFS_IO_HI = 8'h30;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_INTR_BRIDGE = 8'h3C;

  // field positions
  localparam int IO_LIMIT_LSB = 16;
  localparam int BCTL_PARITY_BIT = 16;
  localparam int BCTL_SERR_BIT = 17;
  localparam int BCTL_ALIAS_BIT = 18;

  // reset and fixed values
  localparam logic [31:0] PREF_LIMIT_HI_RST = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RST = 16'h0000;
  localparam logic [2:0] BCTL_RST = 3'h0;
  localparam logic [7:0] CAP_PTR_VALUE = 8'hDC;
  localparam logic [7:0] INTR_PIN_VALUE = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // legacy alias geometry: below 64KB, offsets 100h..3FFh of each 1KB block
  localparam logic [15:0] ALIAS_SPACE_TOP = 16'h0000;
  localparam logic [1:0] ALIAS_LOW_QUARTER = 2'h0;

  // lower window fill values
  localparam logic [11:0] IO_BASE_FILL = 12'h000;
  localparam logic [11:0] IO_LIMIT_FILL = 12'hFFF;
  localparam logic [19:0] PREF_BASE_FILL = 20'h00000;
  localparam logic [19:0] PREF_LIMIT_FILL = 20'hFFFFF;

  // configuration access from the primary side
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] offset;
    logic [3:0] byteEn;
    logic [31:0] data;
  } bwc_cfg_req_t;

  // lower window fields held elsewhere in config space
  typedef struct packed {
    logic [3:0] ioBaseLow;
    logic [3:0] ioLimitLow;
    logic [31:0] prefBaseHigh;
    logic [11:0] prefBaseLow;
    logic [11:0] prefLimitLow;
  } bwc_window_low_t;

  // address presented for a forwarding decision
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } bwc_lookup_t;

endpackage

// ---- logic/bwc_regs.sv ----
// bridge window upper-half registers, capability pointer, interrupt pin and low bridge control
`timescale 1ns/1ps
module bwc_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // configuration access
  input wire bwc_pkg::bwc_cfg_req_t cfgReq,
  output logic [31:0] cfgReadData,
  output logic cfgReadValid,
  // lower window fields
  input wire bwc_pkg::bwc_window_low_t windowLow,
  // downstream memory and I/O lookups
  input wire bwc_pkg::bwc_lookup_t memLookup,
  input wire bwc_pkg::bwc_lookup_t ioLookup,
  output logic memForward,
  output logic ioForwardDown,
  output logic lookupValid,
  // upstream I/O lookup from the secondary side
  input wire bwc_pkg::bwc_lookup_t ioUpLookup,
  output logic ioForwardUp,
  output logic ioUpValid,
  // secondary error inputs and primary reports
  input wire logic secParityError,
  input wire logic secondary_system_error_n,
  output logic secParityReport,
  output logic primarySystemError_n,
  // control bits for the rest of the bridge
  output logic parityResponseEn
);

  // register state
  logic [31:0] prefLimitHigh_reg, prefLimitHigh_next;
  logic [15:0] ioBaseHigh_reg, ioBaseHigh_next;
  logic [15:0] ioLimitHigh_reg, ioLimitHigh_next;
  logic [2:0] bridgeCtl_reg, bridgeCtl_next;
  logic [31:0] readData_reg, readData_next;
  logic readValid_reg, readValid_next;

  // decision state
  logic memFwd_reg, memFwd_next;
  logic ioDown_reg, ioDown_next;
  logic lookValid_reg, lookValid_next;
  logic ioUp_reg, ioUp_next;
  logic upValid_reg, upValid_next;
  logic parRep_reg, parRep_next;
  logic serrN_reg, serrN_next;

  // bridge control fields and alias filter terms
  logic parityRespBit, serrFwdBit, aliasBlockBit;
  logic ioBlockDown, ioReturnUp;

  // full window bounds and hit terms
  logic [63:0] prefBase, prefLimit;
  logic [31:0] ioBase, ioLimit;
  logic memInWin, ioInWin, ioUpInWin, ioAlias, ioUpAlias;

  // join upper halves with the lower fields
  assign prefBase = {windowLow.prefBaseHigh, windowLow.prefBaseLow, bwc_pkg::PREF_BASE_FILL};
  assign prefLimit = {prefLimitHigh_reg, windowLow.prefLimitLow, bwc_pkg::PREF_LIMIT_FILL};

  // i/o bounds fill the low twelve address bits
  assign ioBase = {ioBaseHigh_reg, windowLow.ioBaseLow, bwc_pkg::IO_BASE_FILL};
  assign ioLimit = {ioLimitHigh_reg, windowLow.ioLimitLow, bwc_pkg::IO_LIMIT_FILL};

  // range compares and legacy alias detection
  assign memInWin = (memLookup.addr >= prefBase) && (memLookup.addr <= prefLimit);
  assign ioInWin = (ioLookup.addr[31:0] >= ioBase) && (ioLookup.addr[31:0] <= ioLimit);
  assign ioUpInWin = (ioUpLookup.addr[31:0] >= ioBase) && (ioUpLookup.addr[31:0] <= ioLimit);

  // legacy aliases: below 64KB, upper three quarters of each 1KB block
  assign ioAlias = (ioLookup.addr[31:16] == bwc_pkg::ALIAS_SPACE_TOP)
      && (ioLookup.addr[9:8] != bwc_pkg::ALIAS_LOW_QUARTER);
  assign ioUpAlias = (ioUpLookup.addr[31:16] == bwc_pkg::ALIAS_SPACE_TOP)
      && (ioUpLookup.addr[9:8] != bwc_pkg::ALIAS_LOW_QUARTER);

  // bridge control fields, indexed from their config bit positions
  assign parityRespBit = bridgeCtl_reg[bwc_pkg::BCTL_PARITY_BIT - bwc_pkg::BCTL_PARITY_BIT];
  assign serrFwdBit = bridgeCtl_reg[bwc_pkg::BCTL_SERR_BIT - bwc_pkg::BCTL_PARITY_BIT];
  assign aliasBlockBit = bridgeCtl_reg[bwc_pkg::BCTL_ALIAS_BIT - bwc_pkg::BCTL_PARITY_BIT];

  // aliases dropped downstream are claimed for the upstream path instead
  assign ioBlockDown = aliasBlockBit && ioAlias;
  assign ioReturnUp = aliasBlockBit && ioUpAlias && ioUpInWin;

  // config writes, byte lanes gated by their enables
  always_comb begin
    prefLimitHigh_next = prefLimitHigh_reg;
    ioBaseHigh_next = ioBaseHigh_reg;
    ioLimitHigh_next = ioLimitHigh_reg;
    bridgeCtl_next = bridgeCtl_reg;
    if (cfgReq.write) begin
      case (cfgReq.offset)
        bwc_pkg::OFS_PREF_LIMIT_HI: begin
          for (int b = 0; b < 4; b++) begin
            if (cfgReq.byteEn[b]) begin
              prefLimitHigh_next[b*8 +: 8] = cfgReq.data[b*8 +: 8];
            end
          end
        end
        // lanes 0-1 base upper half, lanes 2-3 limit upper half
        bwc_pkg::OFS_IO_HI: begin
          for (int b = 0; b < 2; b++) begin
            if (cfgReq.byteEn[b]) begin
              ioBaseHigh_next[b*8 +: 8] = cfgReq.data[b*8 +: 8];
            end
            if (cfgReq.byteEn[b+2]) begin
              ioLimitHigh_next[b*8 +: 8] = cfgReq.data[bwc_pkg::IO_LIMIT_LSB + b*8 +: 8];
            end
          end
        end
        // only lane 2 carries the writable control bits
        bwc_pkg::OFS_INTR_BRIDGE: begin
          if (cfgReq.byteEn[2]) begin
            bridgeCtl_next = cfgReq.data[bwc_pkg::BCTL_ALIAS_BIT:bwc_pkg::BCTL_PARITY_BIT];
          end
        end
        // capability pointer and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end
  end

  // read mux; a read beside a write still returns the old value
  always_comb begin
    readData_next = readData_reg;
    readValid_next = cfgReq.read;
    if (cfgReq.read) begin
      case (cfgReq.offset)
        bwc_pkg::OFS_PREF_LIMIT_HI: readData_next = prefLimitHigh_reg;
        bwc_pkg::OFS_IO_HI: readData_next = {ioLimitHigh_reg, ioBaseHigh_reg};
        bwc_pkg::OFS_CAP_PTR: readData_next = {24'h00_0000, bwc_pkg::CAP_PTR_VALUE};
        bwc_pkg::OFS_INTR_BRIDGE: begin
          readData_next = {13'h0000, bridgeCtl_reg, bwc_pkg::INTR_PIN_VALUE, 8'h00};
        end
        default: readData_next = bwc_pkg::READ_ZERO;
      endcase
    end
  end

  // window and control registers, cleared by reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prefLimitHigh_reg <= bwc_pkg::PREF_LIMIT_HI_RST;
      ioBaseHigh_reg <= bwc_pkg::IO_HI_RST;
      ioLimitHigh_reg <= bwc_pkg::IO_HI_RST;
      bridgeCtl_reg <= bwc_pkg::BCTL_RST;
    end else begin
      prefLimitHigh_reg <= prefLimitHigh_next;
      ioBaseHigh_reg <= ioBaseHigh_next;
      ioLimitHigh_reg <= ioLimitHigh_next;
      bridgeCtl_reg <= bridgeCtl_next;
    end
  end

  // read answer flops; data holds until the next read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      readData_reg <= bwc_pkg::READ_ZERO;
      readValid_reg <= 1'b0;
    end else begin
      readData_reg <= readData_next;
      readValid_reg <= readValid_next;
    end
  end

  // forwarding decisions and error gating
  always_comb begin
    memFwd_next = memLookup.valid && memInWin;
    ioDown_next = ioLookup.valid && ioInWin && !ioBlockDown;
    lookValid_next = memLookup.valid || ioLookup.valid;
    ioUp_next = ioUpLookup.valid && (!ioUpInWin || ioReturnUp);
    upValid_next = ioUpLookup.valid;
    parRep_next = secParityError && parityRespBit;
    serrN_next = !(serrFwdBit && !secondary_system_error_n);
  end

  // decision and error flops; the primary error line idles high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memFwd_reg <= 1'b0;
      ioDown_reg <= 1'b0;
      lookValid_reg <= 1'b0;
      ioUp_reg <= 1'b0;
      upValid_reg <= 1'b0;
      parRep_reg <= 1'b0;
      serrN_reg <= 1'b1;
    end else begin
      memFwd_reg <= memFwd_next;
      ioDown_reg <= ioDown_next;
      lookValid_reg <= lookValid_next;
      ioUp_reg <= ioUp_next;
      upValid_reg <= upValid_next;
      parRep_reg <= parRep_next;
      serrN_reg <= serrN_next;
    end
  end

  // outputs straight from flip-flops
  assign cfgReadData = readData_reg;
  assign cfgReadValid = readValid_reg;
  assign memForward = memFwd_reg;
  assign ioForwardDown = ioDown_reg;
  assign lookupValid = lookValid_reg;
  assign ioForwardUp = ioUp_reg;
  assign ioUpValid = upValid_reg;
  assign secParityReport = parRep_reg;
  assign primarySystemError_n = serrN_reg;
  assign parityResponseEn = parityRespBit;

endmodule

// ---- testbench/bwc_regs_properties.sv ----
// assertion checker for the bridge window and control registers
`timescale 1ns/1ps
module bwc_regs_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // configuration access
  input wire bwc_pkg::bwc_cfg_req_t cfgReq,
  input wire logic [31:0] cfgReadData,
  input wire logic cfgReadValid,
  // lookups and decisions
  input wire bwc_pkg::bwc_lookup_t memLookup,
  input wire bwc_pkg::bwc_lookup_t ioLookup,
  input wire bwc_pkg::bwc_lookup_t ioUpLookup,
  input wire logic ioForwardDown,
  input wire logic ioForwardUp,
  input wire logic lookupValid,
  input wire logic ioUpValid,
  // error paths
  input wire logic secParityError,
  input wire logic secondary_system_error_n,
  input wire logic secParityReport,
  input wire logic primarySystemError_n,
  input wire logic parityResponseEn
);
  // one clock domain, checks idle during reset
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_cap_ptr_value: assert property (cfgReq.read && cfgReq.offset == 8'h34 |=> cfgReadData == 32'h0000_00DC)
    else $error("capability pointer value wrong");
  a_intr_pin_zero: assert property (cfgReq.read && cfgReq.offset == 8'h3C |=> cfgReadData[15:0] == 16'h0000)
    else $error("interrupt pin not zero");
  a_unmapped_reads_zero: assert property (cfgReq.read && cfgReq.offset == 8'h38 |=> cfgReadData == 32'h0)
    else $error("unmapped offset not zero");
  a_read_answer_pulse: assert property (cfgReadValid == $past(cfgReq.read))
    else $error("read answer timing wrong");
  a_parity_gated: assert property (secParityReport == ($past(secParityError) && $past(parityResponseEn)))
    else $error("parity report not gated");
  a_serr_needs_input: assert property (!primarySystemError_n |-> !$past(secondary_system_error_n))
    else $error("system error without cause");
  a_lookup_delay: assert property (lookupValid == $past(memLookup.valid || ioLookup.valid))
    else $error("lookup valid timing wrong");
  a_up_delay: assert property (ioUpValid == $past(ioUpLookup.valid))
    else $error("upstream valid timing wrong");
  a_dir_exclusive: assert property (
    ioLookup.valid && ioUpLookup.valid && ioLookup.addr == ioUpLookup.addr |=> ioForwardDown != ioForwardUp)
    else $error("same address forwarded both or neither way");
endmodule

bind bwc_regs bwc_regs_properties bwc_regs_properties_i (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .cfgReq(cfgReq),
  .cfgReadData(cfgReadData),
  .cfgReadValid(cfgReadValid),
  .memLookup(memLookup),
  .ioLookup(ioLookup),
  .ioUpLookup(ioUpLookup),
  .ioForwardDown(ioForwardDown),
  .ioForwardUp(ioForwardUp),
  .lookupValid(lookupValid),
  .ioUpValid(ioUpValid),
  .secParityError(secParityError),
  .secondary_system_error_n(secondary_system_error_n),
  .secParityReport(secParityReport),
  .primarySystemError_n(primarySystemError_n),
  .parityResponseEn(parityResponseEn)
);

// ---- testbench/bwc_sec_agent.sv ----
// secondary-side agent model: parity, system error and upstream I/O
`timescale 1ns/1ps
module bwc_sec_agent (
  // commands from the bench
  input wire logic perr,
  input wire logic serr,
  input wire logic upGo,
  input wire logic [31:0] upAddr,
  // secondary bus signals
  output logic secParityError,
  output logic secondary_system_error_n,
  output bwc_pkg::bwc_lookup_t ioUpLookup
);
  // system error is active low and idles high; address scrambled when idle
  assign secondary_system_error_n = !serr;
  assign secParityError = perr;
  assign ioUpLookup = '{valid: upGo, addr: {32'h0000_0000, upGo ? upAddr : ~upAddr}};
endmodule

// ---- testbench/bwc_regs_tb_top.sv ----
// self-checking bench for the bridge window and control registers
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module bwc_regs_tb_top;
  logic clk_sys = 1'b0, arst_n = 1'b0, upGo = 1'b0, perr = 1'b0, serr = 1'b0, blk = 1'b0;
  bwc_pkg::bwc_cfg_req_t cfgReq = '0;
  bwc_pkg::bwc_window_low_t windowLow = '0;
  bwc_pkg::bwc_lookup_t memLookup = '0, ioLookup = '0, ioUpLookup;
  logic [31:0] cfgReadData, upAddr = '0, limHi = '0, ioHi = '0, a;
  logic cfgReadValid, memForward, ioForwardDown, lookupValid, ioForwardUp, ioUpValid, parityResponseEn;
  logic secParityError, secondary_system_error_n, secParityReport, primarySystemError_n;
  int failures = 0, totalChecks = 0, cycles = 0;
  bwc_regs bwc_regs_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .cfgReq(cfgReq),
    .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid), .windowLow(windowLow),
    .memLookup(memLookup), .ioLookup(ioLookup), .memForward(memForward),
    .ioForwardDown(ioForwardDown), .lookupValid(lookupValid), .ioUpLookup(ioUpLookup),
    .ioForwardUp(ioForwardUp), .ioUpValid(ioUpValid), .secParityError(secParityError),
    .secondary_system_error_n(secondary_system_error_n), .secParityReport(secParityReport),
    .primarySystemError_n(primarySystemError_n), .parityResponseEn(parityResponseEn)
  );
  bwc_sec_agent bwc_sec_agent_i (
    .perr(perr), .serr(serr), .upGo(upGo), .upAddr(upAddr),
    .secParityError(secParityError), .secondary_system_error_n(secondary_system_error_n),
    .ioUpLookup(ioUpLookup)
  );
  // clock and run limit
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic cfgAcc(input logic w, input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfgReq = '{write: w, read: !w, offset: ofs, byteEn: be, data: d};
    @(negedge clk_sys);
    cfgReq = '0;
    if (!w) `CHK(cfgReadData, d)
    `CHK(cfgReadValid, !w)
  endtask
  // expected prefetch window decision
  function automatic logic inMem(input logic [63:0] x);
    return x >= {windowLow.prefBaseHigh, windowLow.prefBaseLow, 20'h00000}
      && x <= {limHi, windowLow.prefLimitLow, 20'hFFFFF};
  endfunction
  // expected I/O decisions
  function automatic logic inIo(input logic [31:0] x);
    return x >= {ioHi[15:0], windowLow.ioBaseLow, 12'h000} && x <= {ioHi[31:16], windowLow.ioLimitLow, 12'hFFF};
  endfunction
  function automatic logic aliasHit(input logic [31:0] x);
    return blk && x[31:16] == 16'h0000 && x[9:8] != 2'h0;
  endfunction
  task automatic errStep(input logic en);
    @(negedge clk_sys);
    {perr, serr} = 2'h3;
    @(negedge clk_sys);
    {perr, serr} = 2'h0;
    `CHK(secParityReport, en)
    `CHK(primarySystemError_n, !en)
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(75399));
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    cfgAcc(1'b0, 8'h2C, 4'hF, 32'h0);
    cfgAcc(1'b0, 8'h30, 4'hF, 32'h0);
    cfgAcc(1'b0, 8'h3C, 4'hF, 32'h0);
    cfgAcc(1'b1, 8'h38, 4'hF, 32'hFFFF_FFFF);
    cfgAcc(1'b0, 8'h38, 4'hF, 32'h0);
    errStep(1'b0);
    cfgAcc(1'b1, 8'h34, 4'hF, 32'h0);
    cfgAcc(1'b0, 8'h34, 4'hF, 32'h0000_00DC);
    cfgAcc(1'b1, 8'h3C, 4'hF, 32'hFFFF_FFFF);
    cfgAcc(1'b0, 8'h3C, 4'hF, 32'h0007_0000);
    `CHK(parityResponseEn, 1'b1)
    errStep(1'b1);
    ioHi = $urandom;
    cfgAcc(1'b1, 8'h30, 4'h3, ioHi);
    cfgAcc(1'b0, 8'h30, 4'hF, {16'h0000, ioHi[15:0]});
    limHi = $urandom;
    cfgAcc(1'b1, 8'h2C, 4'hF, limHi);
    cfgAcc(1'b0, 8'h2C, 4'hF, limHi);
    $display("test registers done");
    // mid-run reset with both error inputs active
    @(negedge clk_sys);
    {arst_n, serr, perr} = 3'b011;
    repeat (2) @(negedge clk_sys);
    `CHK(parityResponseEn, 1'b0)
    arst_n = 1'b1;
    cfgAcc(1'b0, 8'h2C, 4'hF, 32'h0);
    `CHK(primarySystemError_n, 1'b1)
    `CHK(secParityReport, 1'b0)
    {serr, perr} = 2'h0;
    cfgAcc(1'b0, 8'h30, 4'hF, 32'h0);
    cfgAcc(1'b0, 8'h3C, 4'hF, 32'h0);
    $display("test reset done");
    ioHi = 32'h0001_0000;
    limHi = 32'h2;
    cfgAcc(1'b1, 8'h30, 4'hF, ioHi);
    cfgAcc(1'b1, 8'h2C, 4'hF, limHi);
    windowLow.prefBaseHigh = 32'h1;
    for (int i = 0; i < 80; i++) begin
      blk = i >= 40;
      if (i % 40 == 0) cfgAcc(1'b1, 8'h3C, 4'h4, {13'h0, blk, 18'h0});
      windowLow.ioBaseLow = 4'($urandom_range(3));
      windowLow.ioLimitLow = 4'($urandom_range(15, 12));
      {windowLow.prefBaseLow, windowLow.prefLimitLow} = 24'($urandom);
      a = (i % 40 == 0) ? 32'h0000_4100 : (i % 40 == 1) ? 32'h0001_0300 : 32'($urandom_range(32'h1FFFF));
      @(negedge clk_sys);
      ioLookup = '{valid: 1'b1, addr: {32'h0, a}};
      memLookup = '{valid: 1'b1, addr: {32'($urandom_range(3)), $urandom}};
      {upAddr, upGo} = {a, 1'b1};
      @(negedge clk_sys);
      {ioLookup.valid, memLookup.valid, upGo} = 3'h0;
      `CHK(lookupValid, 1'b1)
      `CHK(ioForwardDown, inIo(a) && !aliasHit(a))
      `CHK(ioForwardUp, !inIo(a) || aliasHit(a))
      `CHK(ioUpValid, 1'b1)
      `CHK(memForward, inMem(memLookup.addr))
    end
    $display("test lookups done");
    conclude();
  end
endmodule
